// ---- rtl/psf_consts.svh ----
// Purpose: constants of the pid setpoint/feedback front end
// Assumes: 50 MHz clk_sys; percent values in 0.1 % units
// Notes:   register offsets are parameter-port addresses
//
// Summary of operation
// - setpoint selector codes 0..9 pick keypad, pot, inputs, serial, card, terminals, current
// - setpoint code 0 takes the stored keypad digital value
// - setpoint code 8: terminals 3..1 binary pick sources 0..7, pattern 100 reserved
// - setpoint code 9 uses active current written at link address 0x3011
// - feedback selector codes 0..9, default 2, same channel kinds as setpoint
// - feedback code 9 uses the locally measured active current
// - feedback code 8: terminal pattern picks feedback sources 0..7, 100 reserved
// - keypad digital value spans 0.0 to 100.0 %, default 50.0 %
// - writing keypad digital value updates the monitored setpoint at once
// - keypad config digit 2 lets up/down keys adjust value; next digit keeps it
// - setpoint moves linearly, full span per change time 0.00..60.00 s, default 1.00
// - feedback low-pass filter time 0.000..6.000 s, default 0.010 s
// - feedback multiplied by gain 0.00..10.00, default 1.00
// - feedback range 0.0..100.0 scales only the displayed feedback
`ifndef PSF_CONSTS_SVH
`define PSF_CONSTS_SVH

// ----------------------------------------
// parameter addresses
// ----------------------------------------
`define PSF_A_SP_SEL   16'h0D00
`define PSF_A_KP       16'h0D01
`define PSF_A_RAMP     16'h0D02
`define PSF_A_FB_SEL   16'h0D03
`define PSF_A_FILT     16'h0D04
`define PSF_A_GAIN     16'h0D05
`define PSF_A_RANGE    16'h0D06
`define PSF_A_COMM_CUR 16'h3011

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define PSF_R_SP_SEL   4'h0
`define PSF_R_FB_SEL   4'h2
`define PSF_R_KP       16'h01F4
`define PSF_R_RAMP     16'h0064
`define PSF_R_FILT     16'h000A
`define PSF_R_GAIN     16'h0064
`define PSF_R_RANGE    16'h03E8
`define PSF_PCT_MAX    16'h03E8
`define PSF_TIME_MAX   16'h1770
`define PSF_SEL_MAX    4'h9

// ----------------------------------------
// source codes and fields
// ----------------------------------------
`define PSF_CODE_KP    4'h0
`define PSF_CODE_RSV   4'h4
`define PSF_CODE_TERM  4'h8
`define PSF_CODE_CUR   4'h9
`define PSF_TERM_RSV   3'h4
`define PSF_KEY_DIRECT 4'h2
`define PSF_DIG0_LSB   0
`define PSF_DIG1_LSB   4

// ----------------------------------------
// timing
// ----------------------------------------
`define PSF_CLK_NS       20
`define PSF_RAMP_UNIT_NS 10000000
`define PSF_SPAN_STEPS   1000
`define PSF_RAMP_TICK_CYC ((`PSF_RAMP_UNIT_NS / `PSF_SPAN_STEPS) / `PSF_CLK_NS)
`define PSF_FILT_UNIT_NS 1000000
`define PSF_GAIN_DIV     32'd100
`define PSF_RANGE_DIV    32'd1000

`endif

// ---- rtl/psf_lpf.sv ----
// Purpose: first-order recursive low-pass on the feedback
// Assumes: input step per cycle well below one time unit in cycles
// Notes:   error accumulator instead of a divider
`include "psf_consts.svh"
module psf_lpf #(
    parameter int CYC_PER_UNIT = `PSF_FILT_UNIT_NS / `PSF_CLK_NS
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    input  wire logic              ce,
    // filter data
    input  wire psf_pkg::psf_word_t filt_time,
    input  wire psf_pkg::psf_word_t din,
    output psf_pkg::psf_word_t      dout
);
    psf_pkg::psf_word_t y_reg;
    psf_pkg::psf_word_t y_next;
    logic signed [31:0] acc_reg;
    logic signed [31:0] acc_next;
    logic signed [31:0] tau_cyc;
    logic signed [31:0] err;
    logic signed [31:0] acc_sum;

    // ----------------------------------------
    // filter step
    // ----------------------------------------
    // one lsb per cycle at most: time constant is tau_cyc cycles
    always_comb begin
        tau_cyc  = 32'(filt_time) * 32'(CYC_PER_UNIT);
        err      = $signed({16'h0000, din}) - $signed({16'h0000, y_reg});
        acc_sum  = acc_reg + err;
        y_next   = y_reg;
        acc_next = acc_sum;
        if (filt_time == 16'h0000) begin
            y_next   = din;
            acc_next = 32'sh0;
        end else if (acc_sum >= tau_cyc) begin
            y_next   = y_reg + 16'h0001;
            acc_next = acc_sum - tau_cyc;
        end else if (acc_sum <= -tau_cyc) begin
            y_next   = y_reg - 16'h0001;
            acc_next = acc_sum + tau_cyc;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            y_reg   <= 16'h0000;
            acc_reg <= 32'sh0;
        end else if (ce) begin
            y_reg   <= y_next;
            acc_reg <= acc_next;
        end
    end

    assign dout = y_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_lpf_bypass: assert property ((ce && filt_time == 16'h0000) |=> y_reg == $past(din))
        else $error("zero filter time did not pass feedback");
    a_lpf_slew: assert property ((ce && filt_time != 16'h0000) |=>
        (y_reg == $past(y_reg) || y_reg == $past(y_reg) + 16'h0001 || y_reg == $past(y_reg) - 16'h0001))
        else $error("filter moved more than one lsb");
endmodule

// ---- rtl/psf_pid_front.sv ----
// Purpose: pid setpoint and feedback selection, ramp and conditioning
// Assumes: channel values arrive on clk_sys in 0.1 % units
// Notes:   terminal and key pins are synchronised here
`include "psf_consts.svh"
module psf_pid_front #(
    parameter int FILT_CYC_PER_UNIT = `PSF_FILT_UNIT_NS / `PSF_CLK_NS
) (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               resetn,
    input  wire logic               ce,
    // parameter port
    input  wire logic               param_wr_en,
    input  wire logic               param_rd_en,
    input  wire psf_pkg::psf_word_t param_addr,
    input  wire psf_pkg::psf_word_t param_wr_data,
    output psf_pkg::psf_word_t      param_rd_data,
    output logic                    param_rd_valid,
    // keypad
    input  wire psf_pkg::psf_word_t keypad_function_config,
    input  wire logic               key_up_pin,
    input  wire logic               key_down_pin,
    output logic                    keypad_value_retain,
    // channel values
    input  wire psf_pkg::psf_word_t keypad_pot_value,
    input  wire psf_pkg::psf_word_t first_analog_input,
    input  wire psf_pkg::psf_word_t second_analog_input,
    input  wire psf_pkg::psf_word_t pulse_input,
    input  wire psf_pkg::psf_word_t serial_link_value,
    input  wire psf_pkg::psf_word_t option_card_value,
    input  wire psf_pkg::psf_word_t measured_active_current,
    input  wire logic [2:0]         term_sel_pin,
    // pid front-end results
    output psf_pkg::psf_word_t      pid_setpoint,
    output psf_pkg::psf_word_t      pid_setpoint_monitor,
    output psf_pkg::psf_word_t      pid_feedback,
    output psf_pkg::psf_word_t      pid_feedback_display
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic psf_pkg::psf_word_t sat(input psf_pkg::psf_word_t v);
        sat = (v > `PSF_PCT_MAX) ? `PSF_PCT_MAX : v;
    endfunction

    // terminal code resolves to 0..7; reserved entries read as zero
    function automatic psf_pkg::psf_word_t pick(
        input psf_pkg::psf_code_t   code,
        input logic [2:0]           term,
        input logic [9:0][15:0]     chan
    );
        psf_pkg::psf_code_t c;
        c = (code == `PSF_CODE_TERM) ? {1'b0, term} : code;
        if (c == `PSF_CODE_RSV || c > `PSF_SEL_MAX || c == `PSF_CODE_TERM)
            pick = 16'h0000;
        else
            pick = chan[c];
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [4:0] pin_s1_reg;
    logic [4:0] pin_s2_reg;
    logic [1:0] key_prev_reg;
    logic [4:0] pin_s1_next;
    logic [4:0] pin_s2_next;
    logic [1:0] key_prev_next;
    logic [2:0] term_s;
    logic       up_edge;
    logic       dn_edge;

    always_comb begin
        pin_s1_next   = {key_down_pin, key_up_pin, term_sel_pin};
        pin_s2_next   = pin_s1_reg;
        key_prev_next = pin_s2_reg[4:3];
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pin_s1_reg   <= 5'h00;
            pin_s2_reg   <= 5'h00;
            key_prev_reg <= 2'h0;
        end else if (ce) begin
            pin_s1_reg   <= pin_s1_next;
            pin_s2_reg   <= pin_s2_next;
            key_prev_reg <= key_prev_next;
        end
    end

    assign term_s  = pin_s2_reg[2:0];
    assign up_edge = pin_s2_reg[3] & ~key_prev_reg[0];
    assign dn_edge = pin_s2_reg[4] & ~key_prev_reg[1];

    // ----------------------------------------
    // parameter registers
    // ----------------------------------------
    psf_pkg::psf_code_t sp_sel_reg;
    psf_pkg::psf_code_t sp_sel_next;
    psf_pkg::psf_code_t fb_sel_reg;
    psf_pkg::psf_code_t fb_sel_next;
    psf_pkg::psf_word_t kp_reg;
    psf_pkg::psf_word_t kp_next;
    psf_pkg::psf_word_t ramp_reg;
    psf_pkg::psf_word_t ramp_next;
    psf_pkg::psf_word_t filt_reg;
    psf_pkg::psf_word_t filt_next;
    psf_pkg::psf_word_t gain_reg;
    psf_pkg::psf_word_t gain_next;
    psf_pkg::psf_word_t range_reg;
    psf_pkg::psf_word_t range_next;
    psf_pkg::psf_word_t cur_reg;
    psf_pkg::psf_word_t cur_next;
    logic               retain_next;
    logic               key_direct;

    assign key_direct = keypad_function_config[`PSF_DIG0_LSB +: 4] == `PSF_KEY_DIRECT;

    // a port write in the same cycle as a key edge wins
    always_comb begin
        sp_sel_next = sp_sel_reg;
        fb_sel_next = fb_sel_reg;
        kp_next     = kp_reg;
        ramp_next   = ramp_reg;
        filt_next   = filt_reg;
        gain_next   = gain_reg;
        range_next  = range_reg;
        cur_next    = cur_reg;
        retain_next = keypad_function_config[`PSF_DIG1_LSB +: 4] != 4'h0;
        if (key_direct) begin
            if (up_edge && kp_reg < `PSF_PCT_MAX)
                kp_next = kp_reg + 16'h0001;
            else if (dn_edge && kp_reg != 16'h0000)
                kp_next = kp_reg - 16'h0001;
        end
        if (param_wr_en) begin
            // out-of-range codes are ignored, values saturate
            case (param_addr)
                `PSF_A_SP_SEL:
                    if (param_wr_data <= 16'(`PSF_SEL_MAX))
                        sp_sel_next = param_wr_data[3:0];
                `PSF_A_FB_SEL:
                    if (param_wr_data <= 16'(`PSF_SEL_MAX))
                        fb_sel_next = param_wr_data[3:0];
                `PSF_A_KP:       kp_next    = sat(param_wr_data);
                `PSF_A_RAMP:
                    ramp_next = (param_wr_data > `PSF_TIME_MAX) ? `PSF_TIME_MAX : param_wr_data;
                `PSF_A_FILT:
                    filt_next = (param_wr_data > `PSF_TIME_MAX) ? `PSF_TIME_MAX : param_wr_data;
                `PSF_A_GAIN:     gain_next  = sat(param_wr_data);
                `PSF_A_RANGE:    range_next = sat(param_wr_data);
                `PSF_A_COMM_CUR: cur_next   = sat(param_wr_data);
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sp_sel_reg          <= `PSF_R_SP_SEL;
            fb_sel_reg          <= `PSF_R_FB_SEL;
            kp_reg              <= `PSF_R_KP;
            ramp_reg            <= `PSF_R_RAMP;
            filt_reg            <= `PSF_R_FILT;
            gain_reg            <= `PSF_R_GAIN;
            range_reg           <= `PSF_R_RANGE;
            cur_reg             <= 16'h0000;
            keypad_value_retain <= 1'b0;
        end else if (ce) begin
            sp_sel_reg          <= sp_sel_next;
            fb_sel_reg          <= fb_sel_next;
            kp_reg              <= kp_next;
            ramp_reg            <= ramp_next;
            filt_reg            <= filt_next;
            gain_reg            <= gain_next;
            range_reg           <= range_next;
            cur_reg             <= cur_next;
            keypad_value_retain <= retain_next;
        end
    end

    // ----------------------------------------
    // parameter read
    // ----------------------------------------
    psf_pkg::psf_word_t rd_data_next;

    always_comb begin
        case (param_addr)
            `PSF_A_SP_SEL:   rd_data_next = {12'h000, sp_sel_reg};
            `PSF_A_KP:       rd_data_next = kp_reg;
            `PSF_A_RAMP:     rd_data_next = ramp_reg;
            `PSF_A_FB_SEL:   rd_data_next = {12'h000, fb_sel_reg};
            `PSF_A_FILT:     rd_data_next = filt_reg;
            `PSF_A_GAIN:     rd_data_next = gain_reg;
            `PSF_A_RANGE:    rd_data_next = range_reg;
            `PSF_A_COMM_CUR: rd_data_next = cur_reg;
            default:         rd_data_next = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            param_rd_data  <= 16'h0000;
            param_rd_valid <= 1'b0;
        end else if (ce) begin
            param_rd_data  <= param_rd_en ? rd_data_next : param_rd_data;
            param_rd_valid <= param_rd_en;
        end
    end

    // ----------------------------------------
    // source selection
    // ----------------------------------------
    logic [9:0][15:0]   sp_chan;
    logic [9:0][15:0]   fb_chan;
    psf_pkg::psf_word_t sp_tgt_next;
    psf_pkg::psf_word_t fb_raw_reg;
    psf_pkg::psf_word_t fb_raw_next;

    always_comb begin
        sp_chan    = '{sat(cur_reg), 16'h0000, sat(option_card_value), sat(serial_link_value),
                       sat(pulse_input), 16'h0000, sat(second_analog_input),
                       sat(first_analog_input), sat(keypad_pot_value), kp_reg};
        fb_chan    = sp_chan;
        fb_chan[9] = sat(measured_active_current);
        sp_tgt_next = pick(sp_sel_reg, term_s, sp_chan);
        fb_raw_next = pick(fb_sel_reg, term_s, fb_chan);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pid_setpoint_monitor <= 16'h0000;
            fb_raw_reg           <= 16'h0000;
        end else if (ce) begin
            pid_setpoint_monitor <= sp_tgt_next;
            fb_raw_reg           <= fb_raw_next;
        end
    end

    // ----------------------------------------
    // setpoint ramp
    // ----------------------------------------
    // one lsb per ramp_reg ticks of 10 us: full span per change time
    psf_pkg::psf_word_t tick_reg;
    psf_pkg::psf_word_t tick_next;
    psf_pkg::psf_word_t rcnt_reg;
    psf_pkg::psf_word_t rcnt_next;
    psf_pkg::psf_word_t sp_next;
    logic               tick;

    always_comb begin
        tick      = tick_reg == 16'(`PSF_RAMP_TICK_CYC - 1);
        tick_next = tick ? 16'h0000 : tick_reg + 16'h0001;
        sp_next   = pid_setpoint;
        rcnt_next = rcnt_reg;
        if (ramp_reg == 16'h0000) begin
            sp_next   = pid_setpoint_monitor;
            rcnt_next = 16'h0000;
        end else if (pid_setpoint == pid_setpoint_monitor) begin
            rcnt_next = 16'h0000;
        end else if (tick) begin
            if (rcnt_reg + 16'h0001 >= ramp_reg) begin
                rcnt_next = 16'h0000;
                sp_next   = (pid_setpoint < pid_setpoint_monitor) ? pid_setpoint + 16'h0001
                                                                  : pid_setpoint - 16'h0001;
            end else begin
                rcnt_next = rcnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tick_reg     <= 16'h0000;
            rcnt_reg     <= 16'h0000;
            pid_setpoint <= 16'h0000;
        end else if (ce) begin
            tick_reg     <= tick_next;
            rcnt_reg     <= rcnt_next;
            pid_setpoint <= sp_next;
        end
    end

    // ----------------------------------------
    // feedback conditioning
    // ----------------------------------------
    psf_pkg::psf_word_t fb_filt;
    psf_pkg::psf_word_t fb_ctl_next;
    psf_pkg::psf_word_t fb_disp_next;
    logic [31:0]        gain_prod;
    logic [31:0]        disp_prod;

    psf_lpf #(
        .CYC_PER_UNIT (FILT_CYC_PER_UNIT)
    ) u_lpf (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .ce        (ce),
        .filt_time (filt_reg),
        .din       (fb_raw_reg),
        .dout      (fb_filt)
    );

    // display range touches only the display copy
    always_comb begin
        gain_prod    = 32'(fb_filt) * 32'(gain_reg) / `PSF_GAIN_DIV;
        disp_prod    = 32'(pid_feedback) * 32'(range_reg) / `PSF_RANGE_DIV;
        fb_ctl_next  = gain_prod[15:0];
        fb_disp_next = disp_prod[15:0];
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pid_feedback         <= 16'h0000;
            pid_feedback_display <= 16'h0000;
        end else if (ce) begin
            pid_feedback         <= fb_ctl_next;
            pid_feedback_display <= fb_disp_next;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_kp_write;
        ce && param_wr_en && param_addr == `PSF_A_KP && param_wr_data <= `PSF_PCT_MAX;
    endsequence
    sequence s_cur_write;
        ce && param_wr_en && param_addr == `PSF_A_COMM_CUR && param_wr_data <= `PSF_PCT_MAX;
    endsequence

    a_sp_sel_range: assert property (sp_sel_reg <= `PSF_SEL_MAX)
        else $error("setpoint selector out of range");
    a_fb_sel_range: assert property (fb_sel_reg <= `PSF_SEL_MAX)
        else $error("feedback selector out of range");
    a_kp_range: assert property (kp_reg <= `PSF_PCT_MAX)
        else $error("keypad value above full scale");
    a_sp_keypad: assert property ((ce && sp_sel_reg == `PSF_CODE_KP) |=>
        pid_setpoint_monitor == $past(kp_reg))
        else $error("keypad setpoint not taken");
    a_term_rsv: assert property ((ce && sp_sel_reg == `PSF_CODE_TERM && term_s == `PSF_TERM_RSV) |=>
        pid_setpoint_monitor == 16'h0000)
        else $error("reserved terminal pattern not zero");
    a_fb_term_ai: assert property ((ce && fb_sel_reg == `PSF_CODE_TERM && term_s == 3'h2) |=>
        fb_raw_reg == $past(sat(first_analog_input)))
        else $error("terminal feedback pick wrong");
    a_fb_local_cur: assert property ((ce && fb_sel_reg == `PSF_CODE_CUR) |=>
        fb_raw_reg == $past(sat(measured_active_current)))
        else $error("local current not fed back");
    a_comm_cur: assert property ((s_cur_write ##1 (ce && sp_sel_reg == `PSF_CODE_CUR)) |=>
        pid_setpoint_monitor == $past(param_wr_data, 2))
        else $error("communicated current not used");
    a_kp_monitor: assert property ((s_kp_write ##0 sp_sel_reg == `PSF_CODE_KP
        ##1 (ce && sp_sel_reg == `PSF_CODE_KP)) |=> pid_setpoint_monitor == $past(param_wr_data, 2))
        else $error("monitor not updated by keypad write");
    a_key_up: assert property ((ce && key_direct && up_edge && !param_wr_en && kp_reg < `PSF_PCT_MAX) |=>
        kp_reg == $past(kp_reg) + 16'h0001)
        else $error("up key did not raise keypad value");
    a_ramp_zero: assert property ((ce && ramp_reg == 16'h0000) |=>
        pid_setpoint == $past(pid_setpoint_monitor))
        else $error("zero change time did not follow target");
    a_ramp_slew: assert property ((ce && ramp_reg != 16'h0000) |=>
        (pid_setpoint == $past(pid_setpoint) || pid_setpoint == $past(pid_setpoint) + 16'h0001
         || pid_setpoint == $past(pid_setpoint) - 16'h0001))
        else $error("setpoint jumped during ramp");
    a_unity_gain: assert property ((ce && gain_reg == `PSF_R_GAIN) |=> pid_feedback == $past(fb_filt))
        else $error("unity gain altered feedback");
    a_full_display: assert property ((ce && range_reg == `PSF_PCT_MAX) |=>
        pid_feedback_display == $past(pid_feedback))
        else $error("full range altered display");
endmodule

// ---- rtl/psf_pkg.sv ----
// Purpose: shared types of the pid front end
// Assumes: nothing
// Notes:   constants live in psf_consts.svh
package psf_pkg;
    typedef logic [15:0] psf_word_t;
    typedef logic [3:0]  psf_code_t;
endpackage

// ---- tb/psf_chan_model.sv ----
// Purpose: far-side channel levels for the pid front end
// Assumes: steady same-clock levels, 0.1 % units
// Notes:   all distinct so a wrong pick shows
module psf_chan_model (
    // pot, ai1, ai2, pulse, serial, card, current
    output logic [6:0][15:0] chan
);
    timeunit 1ns;
    timeprecision 1ps;
    assign chan = {16'h02BC, 16'h0258, 16'h01C2, 16'h0190, 16'h012C, 16'h00C8, 16'h0064};
endmodule

// ---- tb/testbench.sv ----
// Purpose: self-checking bench of the pid front end
// Assumes: filter unit shortened to 50 cycles
// Notes:   inputs move 1 ns after the rising edge
`include "psf_consts.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk_sys = 1'b0;
    logic              resetn = 1'b0;
    logic              wr_en = 1'b0;
    logic              rd_en = 1'b0;
    logic              up = 1'b0;
    logic              dn = 1'b0;
    logic [2:0]        term = 3'h0;
    logic [15:0]       addr = 16'h0000;
    logic [15:0]       wdat = 16'h0000;
    logic [15:0]       cfg = 16'h0000;
    logic [15:0]       rdat, sp, mon, fb, disp, x;
    logic [6:0][15:0]  ch;
    logic              rv, ret;
    int                miscompares = 0;
    int                checks = 0;
    int                cyc = 0;
    logic [15:0]       e [10] = '{16'h01F4, 16'h0064, 16'h00C8, 16'h012C, 16'h0000,
                                  16'h0190, 16'h01C2, 16'h0258, 16'h01F4, 16'h0320};
    psf_chan_model i_chan (.chan(ch));
    psf_pid_front #(.FILT_CYC_PER_UNIT(50)) i_dut (
        .clk_sys(clk_sys), .resetn(resetn), .ce(1'b1), .param_wr_en(wr_en), .param_rd_en(rd_en),
        .param_addr(addr), .param_wr_data(wdat), .param_rd_data(rdat), .param_rd_valid(rv),
        .keypad_function_config(cfg), .key_up_pin(up), .key_down_pin(dn), .keypad_value_retain(ret),
        .keypad_pot_value(ch[0]), .first_analog_input(ch[1]), .second_analog_input(ch[2]),
        .pulse_input(ch[3]), .serial_link_value(ch[4]), .option_card_value(ch[5]),
        .measured_active_current(ch[6]), .term_sel_pin(term), .pid_setpoint(sp),
        .pid_setpoint_monitor(mon), .pid_feedback(fb), .pid_feedback_display(disp));
    always #10 clk_sys = ~clk_sys;
    task automatic cmp_w(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_b(input logic ok);
        checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("CHECK FAILED at %0t: flag wrong", $time);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        addr = a;
        wdat = d;
        wr_en = 1'b1;
        tick(1);
        wr_en = 1'b0;
        tick(1);
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] d);
        addr = a;
        rd_en = 1'b1;
        tick(1);
        rd_en = 1'b0;
        cmp_b(rv);
        cmp_w(rdat, d);
        tick(1);
    endtask
    task automatic press(input logic u, input logic [15:0] c, input logic [15:0] kp);
        cfg = c;
        up = u;
        dn = !u;
        tick(5);
        up = 1'b0;
        dn = 1'b0;
        tick(5);
        rd_chk(16'h0D01, kp);
        cmp_b(ret === (c[7:4] != 4'h0));
    endtask
    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        tick(20);
        resetn = 1'b1;
        rd_chk(16'h0D00, 16'h0000);
        rd_chk(16'h0D01, `PSF_R_KP);
        rd_chk(16'h0D02, `PSF_R_RAMP);
        rd_chk(16'h0D03, 16'h0002);
        rd_chk(16'h0D04, `PSF_R_FILT);
        rd_chk(16'h0D05, `PSF_R_GAIN);
        rd_chk(16'h0D06, `PSF_R_RANGE);
        rd_chk(16'h0D07, 16'h0000);
        wr(16'h0D00, 16'h000A);
        rd_chk(16'h0D00, 16'h0000);
        $display("registers done");
        // comm current set, then every setpoint code and terminal pattern; feedback on local current
        wr(16'h0D03, 16'h0009);
        wr(16'h3011, 16'h0320);
        for (int c = 0; c < 10; c++) begin
            wr(16'h0D00, 16'(c));
            tick(5);
            cmp_w(mon, e[c]);
        end
        wr(16'h3011, 16'h02EE);
        tick(3);
        cmp_w(mon, 16'h02EE);
        wr(16'h0D00, 16'h0008);
        for (int p = 0; p < 8; p++) begin
            term = 3'(p);
            tick(6);
            cmp_w(mon, e[p]);
        end
        $display("setpoint select done");
        term = 3'h2;
        wr(16'h0D04, 16'h0000);
        wr(16'h0D06, 16'h01F4);
        for (int c = 0; c < 10; c++) begin
            x = (c == 9) ? ch[6] : (c == 8) ? e[term] : e[c];
            wr(16'h0D03, 16'(c));
            tick(8);
            cmp_w(fb, x);
            cmp_w(disp, x / 2);
        end
        wr(16'h0D05, 16'h00C8);
        tick(8);
        cmp_w(fb, 16'h0578);
        wr(16'h0D04, 16'h000A);
        wr(16'h0D03, 16'h0001);
        tick(20);
        cmp_b(fb > 16'h00C8 && fb < 16'h0578);
        tick(6000);
        cmp_b(fb >= 16'h00C8 && fb <= 16'h00CC);
        $display("feedback done");
        wr(16'h0D00, 16'h0000);
        wr(16'h0D02, 16'h0000);
        wr(16'h0D01, 16'h012C);
        tick(4);
        cmp_w(mon, 16'h012C);
        cmp_w(sp, 16'h012C);
        wr(16'h0D02, 16'h0001);
        wr(16'h0D01, 16'h0190);
        tick(3);
        cmp_w(mon, 16'h0190);
        tick(2500);
        cmp_b(sp >= 16'h012F && sp <= 16'h0132);
        $display("ramp done");
        press(1'b1, 16'h0012, 16'h0191);
        press(1'b0, 16'h0000, 16'h0191);
        press(1'b0, 16'h0002, 16'h0190);
        $display("keys done");
        complete_run();
    end
endmodule
